// *** logic/iocm_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module iocm_decode
  import iocm_pkg::*;
#(
  parameter int CH = NUM_CH
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 instr_valid,
  input  wire logic [WORD_W-1:0]    instr_word,
  input  wire logic [2*CH-1:0]      disconnect,
  input  wire logic                 int_sys_enable,
  input  wire logic [2*CH-1:0]      zero_count_event,
  input  wire logic [2*CH-1:0]      record_end_event,
  input  wire logic [2*CH-1:0]      input_dir,
  input  wire logic [2*CH-1:0]      prio_grant,
  output logic [2*CH-1:0]           io_mode_select_r,
  output logic [2*CH-1:0]           record_end_arm_r,
  output logic [2*CH-1:0]           zero_count_arm_r,
  output logic [2*CH*FC_W-1:0]      terminal_function_code_r,
  output logic [2*CH-1:0]           addr_high_r,
  output logic [2*CH*HI_CNT_W-1:0]  word_count_upper_r,
  output logic [2*CH-1:0]           int_active_r,
  output logic [2*CH-1:0]           int_waiting_r,
  output logic [2*CH-1:0]           auto_disconnect_r
);
  import iocm_pkg::*;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  function automatic logic fbit(input logic [WORD_W-1:0] w, input int pos);
    fbit = w[WORD_W-1-pos];
  endfunction

  logic [OPC_W-1:0]    opc;
  logic [CLS_W-1:0]    cls;
  logic [CH_IDX_W-1:0] sel;
  logic                is_std;
  logic                is_dir;
  iocm_ch_cfg_t        new_cfg;

  always_comb begin
    opc = instr_word[WORD_W-1-POS_OPC_LO +: OPC_W];
    cls = instr_word[WORD_W-1-POS_CLS_LO +: CLS_W];
    sel = {fbit(instr_word, POS_CH_HI), fbit(instr_word, POS_CH_LO)};
    is_std = instr_valid && (opc == OPC_STD) && (cls == CLS_IO);
    is_dir = instr_valid && (opc == OPC_DIR) && (cls == CLS_IO);
  end

  // ----------------------------------------------------------------
  // Field capture
  // ----------------------------------------------------------------
  always_comb begin
    new_cfg = CFG_RESET;
    new_cfg.io_mode_select = fbit(instr_word, POS_MODE);
    new_cfg.record_end_arm = fbit(instr_word, POS_REC_ARM);
    new_cfg.zero_count_arm = fbit(instr_word, POS_ZC_ARM);
    new_cfg.terminal_function_code = instr_word[WORD_W-1-POS_FC_LO +: FC_W];
    new_cfg.addr_high = fbit(instr_word, POS_ADDR_HI);
    new_cfg.word_count_upper = instr_word[WORD_W-1-POS_CNT_LO +: HI_CNT_W];
  end

  // ----------------------------------------------------------------
  // Per-channel state
  // ----------------------------------------------------------------
  iocm_ch_cfg_t cfg     [2*CH];
  iocm_ch_cfg_t eff_cfg [2*CH];
  logic [2*CH-1:0] load;

  genvar g;
  generate
    for (g = 0; g < 2*CH; g++) begin : g_ch
      localparam bit DIRECT = (g >= CH);
      always_comb begin
        eff_cfg[g] = new_cfg;
        if (!DIRECT && !new_cfg.io_mode_select) begin
          eff_cfg[g].record_end_arm         = 1'b0;
          eff_cfg[g].zero_count_arm         = 1'b0;
          eff_cfg[g].terminal_function_code = FC_RECORD_THEN_DISCONNECT;
        end
        if (DIRECT) begin
          eff_cfg[g].io_mode_select = 1'b1;
        end
      end
      assign load[g] = (DIRECT ? is_dir : is_std) && (sel == CH_IDX_W'(g % CH));
      iocm_ch_state u_state (
        .clk        (clk),
        .rst        (rst),
        .load       (load[g]),
        .load_cfg   (eff_cfg[g]),
        .disconnect (disconnect[g] | auto_disconnect_r[g]),
        .force_ext  (1'(DIRECT)),
        .cfg_r      (cfg[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Mode and arm outputs
  // ----------------------------------------------------------------
  logic [2*CH-1:0]      mode_nxt;
  logic [2*CH-1:0]      rarm_nxt;
  logic [2*CH-1:0]      zarm_nxt;
  logic [2*CH*FC_W-1:0] fc_nxt;

  always_comb begin
    mode_nxt = '0;
    rarm_nxt = '0;
    zarm_nxt = '0;
    fc_nxt   = '0;
    for (int i = 0; i < 2*CH; i++) begin
      mode_nxt[i]            = cfg[i].io_mode_select;
      rarm_nxt[i]            = cfg[i].record_end_arm;
      zarm_nxt[i]            = cfg[i].zero_count_arm;
      fc_nxt[i*FC_W +: FC_W] = cfg[i].terminal_function_code;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_mode_select_r         <= '0;
      record_end_arm_r         <= '0;
      zero_count_arm_r         <= '0;
      terminal_function_code_r <= '0;
    end else begin
      io_mode_select_r         <= mode_nxt;
      record_end_arm_r         <= rarm_nxt;
      zero_count_arm_r         <= zarm_nxt;
      terminal_function_code_r <= fc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Address and count outputs
  // ----------------------------------------------------------------
  logic [2*CH-1:0]          ahi_nxt;
  logic [2*CH*HI_CNT_W-1:0] cnt_nxt;

  always_comb begin
    ahi_nxt = '0;
    cnt_nxt = '0;
    for (int i = 0; i < 2*CH; i++) begin
      ahi_nxt[i]                      = cfg[i].addr_high;
      cnt_nxt[i*HI_CNT_W +: HI_CNT_W] = cfg[i].word_count_upper;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_high_r        <= '0;
      word_count_upper_r <= '0;
    end else begin
      addr_high_r        <= ahi_nxt;
      word_count_upper_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  logic [2*CH-1:0] ext_ev;
  logic [2*CH-1:0] cmp_ev;
  logic [2*CH-1:0] ev;

  always_comb begin
    ext_ev = '0;
    cmp_ev = '0;
    ev     = '0;
    for (int i = 0; i < 2*CH; i++) begin
      ext_ev[i] = (cfg[i].record_end_arm && record_end_event[i]) ||
                  (cfg[i].zero_count_arm && zero_count_event[i]);
      cmp_ev[i] = record_end_event[i] || zero_count_event[i];
      ev[i]     = cfg[i].io_mode_select ? ext_ev[i] : cmp_ev[i];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt level state
  // ----------------------------------------------------------------
  logic [2*CH-1:0] act_nxt;
  logic [2*CH-1:0] wait_nxt;

  always_comb begin
    act_nxt  = int_active_r;
    wait_nxt = int_waiting_r;
    for (int i = 0; i < 2*CH; i++) begin
      // Grant services the active level
      if (int_active_r[i] && prio_grant[i]) begin
        act_nxt[i] = 1'b0;
      end
      if (int_waiting_r[i] && int_sys_enable && prio_grant[i]) begin
        wait_nxt[i] = 1'b0;
        act_nxt[i]  = 1'b1;
      end
      if (ev[i]) begin
        if (int_sys_enable) begin
          act_nxt[i] = 1'b1;
        end else begin
          wait_nxt[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_active_r  <= '0;
      int_waiting_r <= '0;
    end else begin
      int_active_r  <= act_nxt;
      int_waiting_r <= wait_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Terminal function decode
  // ----------------------------------------------------------------
  logic [2*CH-1:0] stop_sel;

  always_comb begin
    stop_sel = '0;
    for (int i = 0; i < 2*CH; i++) begin
      stop_sel[i] = cfg[i].io_mode_select &&
                    (cfg[i].terminal_function_code == FC_SIGNAL_THEN_DISCONNECT);
    end
  end

  // ----------------------------------------------------------------
  // Automatic disconnect
  // ----------------------------------------------------------------
  logic [2*CH-1:0] adisc_nxt;

  always_comb begin
    adisc_nxt = '0;
    for (int i = 0; i < 2*CH; i++) begin
      if (stop_sel[i] && input_dir[i] && (zero_count_event[i] || record_end_event[i])) begin
        adisc_nxt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      auto_disconnect_r <= '0;
    end else begin
      auto_disconnect_r <= adisc_nxt;
    end
  end
endmodule
`default_nettype wire

// *** logic/iocm_pkg.sv ***
package iocm_pkg;
  // Word layout, bit 0 is the most significant bit of a 24-bit word
  localparam int WORD_W      = 24;
  localparam int NUM_CH      = 4;
  localparam int CH_IDX_W    = 2;
  localparam int FC_W        = 2;
  localparam int HI_CNT_W    = 5;
  localparam int OPC_W       = 6;
  localparam int CLS_W       = 2;

  // Instruction fields, given as bit number from the word's left end
  localparam int POS_OPC_LO  = 8;
  localparam int POS_CLS_LO  = 11;
  localparam int POS_MODE    = 12;
  localparam int POS_REC_ARM = 13;
  localparam int POS_ZC_ARM  = 14;
  localparam int POS_FC_LO   = 16;
  localparam int POS_ADDR_HI = 18;
  localparam int POS_CNT_LO  = 23;
  localparam int POS_CH_HI   = 0;
  localparam int POS_CH_LO   = 9;

  localparam logic [OPC_W-1:0] OPC_STD = 6'h02;
  localparam logic [OPC_W-1:0] OPC_DIR = 6'h06;
  localparam logic [CLS_W-1:0] CLS_IO  = 2'h1;

  localparam logic [FC_W-1:0] FC_RECORD_THEN_DISCONNECT = 2'h0;
  localparam logic [FC_W-1:0] FC_SIGNAL_THEN_DISCONNECT = 2'h1;

  typedef struct packed {
    logic                io_mode_select;
    logic                record_end_arm;
    logic                zero_count_arm;
    logic [FC_W-1:0]     terminal_function_code;
    logic                addr_high;
    logic [HI_CNT_W-1:0] word_count_upper;
  } iocm_ch_cfg_t;

  localparam iocm_ch_cfg_t CFG_RESET = '0;
endpackage

// *** logic/iocm_ch_state.sv ***
`timescale 1ns/1ps
`default_nettype none
module iocm_ch_state
  import iocm_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire iocm_ch_cfg_t load_cfg,
  input  wire logic         disconnect,
  input  wire logic         force_ext,
  output iocm_ch_cfg_t      cfg_r
);
  iocm_ch_cfg_t cfg_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    if (load) begin
      cfg_nxt = load_cfg;
    end else if (disconnect) begin
      cfg_nxt.record_end_arm = 1'b0;
      cfg_nxt.zero_count_arm = 1'b0;
    end
    if (force_ext) begin
      cfg_nxt.io_mode_select = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end
endmodule
`default_nettype wire

// *** sim/iocm_decode_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module iocm_decode_monitor
  import iocm_pkg::*;
#(
  parameter int CH = NUM_CH
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     instr_valid,
  input wire logic [WORD_W-1:0]        instr_word,
  input wire logic [2*CH-1:0]          disconnect,
  input wire logic                     int_sys_enable,
  input wire logic [2*CH-1:0]          io_mode_select_r,
  input wire logic [2*CH-1:0]          record_end_arm_r,
  input wire logic [2*CH-1:0]          zero_count_arm_r,
  input wire logic [2*CH*FC_W-1:0]     terminal_function_code_r,
  input wire logic [2*CH-1:0]          addr_high_r,
  input wire logic [2*CH*HI_CNT_W-1:0] word_count_upper_r,
  input wire logic [2*CH-1:0]          int_active_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic       cls = instr_word[13:12] == CLS_IO;
  wire logic       tks = instr_valid && cls && instr_word[20:15] == OPC_STD;
  wire logic       tkd = instr_valid && cls && instr_word[20:15] == OPC_DIR;
  wire logic       ext = (tks && instr_word[11]) || tkd;
  wire logic [2:0] ch  = {tkd, instr_word[23], instr_word[14]};
  sequence ext_take; ext; endsequence
  sequence cmp_take; tks && !instr_word[11]; endsequence
  sequence any_take; tks || tkd; endsequence
  mode_sel_a: assert property (any_take |-> ##2 io_mode_select_r[$past(ch, 2)] == $past(ext, 2))
    else $error("mode wrong");
  compat_off_a: assert property (cmp_take |-> ##2 !record_end_arm_r[$past(ch, 2)] && !zero_count_arm_r[$past(ch, 2)])
    else $error("compatible arm set");
  rec_arm_a: assert property (ext_take |-> ##2 record_end_arm_r[$past(ch, 2)] == $past(instr_word[10], 2))
    else $error("record arm wrong");
  zc_arm_a: assert property (ext_take |-> ##2 zero_count_arm_r[$past(ch, 2)] == $past(instr_word[9], 2))
    else $error("count arm wrong");
  fc_sel_a: assert property (ext_take |-> ##2 terminal_function_code_r[FC_W*$past(ch, 2) +: FC_W] == $past(instr_word[8:7], 2))
    else $error("function wrong");
  count_hi_a: assert property (any_take |-> ##2 word_count_upper_r[HI_CNT_W*$past(ch, 2) +: HI_CNT_W] == $past(instr_word[4:0], 2))
    else $error("count wrong");
  addr_hi_a: assert property (any_take |-> ##2 addr_high_r[$past(ch, 2)] == $past(instr_word[5], 2))
    else $error("address bit wrong");
  disc_clr_a: assert property (disconnect != '0 && !instr_valid |-> ##2 ((record_end_arm_r | zero_count_arm_r) & $past(disconnect, 2)) == '0)
    else $error("arm kept after disconnect");
  int_gate_a: assert property (!int_sys_enable [*3] |=> (int_active_r & ~$past(int_active_r)) == '0)
    else $error("active while disabled");
endmodule
bind iocm_decode iocm_decode_monitor #(.CH(CH)) i_iocm_decode_monitor (.clk, .rst, .instr_valid, .instr_word,
  .disconnect, .int_sys_enable, .io_mode_select_r, .record_end_arm_r, .zero_count_arm_r, .terminal_function_code_r,
  .addr_high_r, .word_count_upper_r, .int_active_r);
`default_nettype wire

// *** sim/iocm_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module iocm_cpu_model
  import iocm_pkg::*;
(
  input  wire logic              clk,
  output var logic               instr_valid,
  output var logic [WORD_W-1:0]  instr_word
);
  initial {instr_valid, instr_word} = '0;
  // One word for one cycle, then its complement as the idle word
  task automatic issue(input logic [WORD_W-1:0] w);
    @(posedge clk);
    #1;
    instr_valid = 1'b1;
    instr_word  = w;
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
    instr_word  = ~w;
  endtask
endmodule
`default_nettype wire

// *** sim/iocm_decode_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module iocm_decode_tb_top;
  import iocm_pkg::*;
  logic        clk, rst, int_sys_enable, instr_valid;
  logic [23:0] instr_word;
  logic [7:0]  disconnect, zero_count_event, record_end_event, input_dir, prio_grant;
  logic [7:0]  io_mode_select_r, record_end_arm_r, zero_count_arm_r, addr_high_r, int_active_r, int_waiting_r;
  logic [7:0]  auto_disconnect_r;
  logic [15:0] terminal_function_code_r;
  logic [39:0] word_count_upper_r;
  int          bad_count = 0;
  int          tests_run = 0;
  iocm_cpu_model i_iocm_cpu_model (.clk, .instr_valid, .instr_word);
  iocm_decode i_iocm_decode (.clk, .rst, .instr_valid, .instr_word, .disconnect, .int_sys_enable, .zero_count_event,
    .record_end_event, .input_dir, .prio_grant, .io_mode_select_r, .record_end_arm_r, .zero_count_arm_r,
    .terminal_function_code_r, .addr_high_r, .word_count_upper_r, .int_active_r, .int_waiting_r,
    .auto_disconnect_r);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Unused bits 1, 2 and 17 always set
  function automatic logic [23:0] mk(input logic [2:0] c, input logic e, r, z, input logic [1:0] f, input logic a,
                                      input logic [4:0] n);
    return {c[1], 2'h3, c[2] ? OPC_DIR : OPC_STD, c[0], CLS_IO, e, r, z, f, 1'b1, a, n};
  endfunction
  function automatic logic [10:0] cfg(input int i);
    return {io_mode_select_r[i], record_end_arm_r[i], zero_count_arm_r[i], terminal_function_code_r[2*i+:2],
            addr_high_r[i], word_count_upper_r[5*i+:5]};
  endfunction
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    settle();
    chk(io_mode_select_r, 8'hF0);
    chk({terminal_function_code_r, record_end_arm_r, zero_count_arm_r}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_std();
    for (int i = 0; i < 4; i++) i_iocm_cpu_model.issue(mk(3'(i), 1'b1, i[0], i[1], 2'(i), i[0], 5'(16 + i)));
    settle();
    for (int i = 0; i < 4; i++) chk(cfg(i), {1'b1, i[0], i[1], 2'(i), i[0], 5'(16 + i)});
    i_iocm_cpu_model.issue(mk(3'h1, 1'b0, 1'b1, 1'b1, 2'h3, 1'b0, 5'h02));
    i_iocm_cpu_model.issue(mk(3'h4, 1'b0, 1'b1, 1'b0, 2'h1, 1'b1, 5'h1F));
    i_iocm_cpu_model.issue(mk(3'h0, 1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 5'h00) ^ 24'h003000);
    i_iocm_cpu_model.issue(mk(3'h0, 1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 5'h00) ^ 24'h008000);
    settle();
    chk(cfg(1), {5'h00, 1'b0, 5'h02});
    chk(cfg(4), {5'h19, 1'b1, 5'h1F});
    chk(cfg(0), {5'h10, 1'b0, 5'h10});
    $display("decode test done");
  endtask
  task automatic t_int();
    int n;
    @(posedge clk);
    #1;
    record_end_event = 8'h08;
    @(posedge clk);
    #1;
    record_end_event = 8'h00;
    settle();
    chk({int_active_r[3], int_waiting_r[3]}, 2'h1);
    int_sys_enable = 1'b1;
    prio_grant = 8'h08;
    for (n = 0; n < 10 && int_active_r[3] !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk(int_active_r[3], 1'b1);
    if (int_active_r[3] !== 1'b1) test_done();
    $display("interrupt test done");
  endtask
  task automatic t_disc();
    @(posedge clk);
    #1;
    disconnect = 8'h04;
    @(posedge clk);
    #1;
    disconnect = 8'h00;
    settle();
    chk({record_end_arm_r[3:2], zero_count_arm_r[3:2]}, 4'hA);
    $display("disconnect test done");
  endtask
  task automatic t_auto();
    i_iocm_cpu_model.issue(mk(3'h2, 1'b1, 1'b1, 1'b1, 2'h1, 1'b0, 5'h00));
    settle();
    input_dir = 8'h04;
    zero_count_event = 8'h06;
    @(posedge clk);
    #1;
    zero_count_event = 8'h00;
    chk(auto_disconnect_r[2], 1'b1);
    chk(int_active_r[1], 1'b1);
    settle();
    chk({record_end_arm_r[2], zero_count_arm_r[2], auto_disconnect_r[2]}, 3'h0);
    $display("auto disconnect test done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rst, int_sys_enable} = 2'h2;
    {disconnect, zero_count_event, record_end_event, input_dir, prio_grant} = '0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_std();
    t_int();
    t_disc();
    t_auto();
    test_done();
  end
endmodule
`default_nettype wire
